//--- logic/ddr2_burst_pkg.sv
// Purpose: constants and types for the DDR2 burst read/write data path
// Assumes: sixteen-bit organisation, small flip-flop array as storage
// Notes: mode fields sit at their address-bit positions in the set command

package ddr2_burst_pkg;

  // ==========================================================
  // widths and depths
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int COL_W = 4;
  localparam int MEM_DEPTH = 16;
  localparam int SLOT_W = 4;
  localparam int NUM_SLOTS = 16;
  localparam int SYNC_W = 40;

  // ==========================================================
  // mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_RDQS_BIT = 11;
  localparam logic [BA_W-1:0] BA_MR = 2'h0;
  localparam logic [BA_W-1:0] BA_EMR = 2'h1;

  // ==========================================================
  // legal codes and values after reset
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h7;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic RST_BL8 = 1'b0;
  localparam logic RST_ILV = 1'b0;
  localparam logic [2:0] RST_CL = 3'h3;
  localparam logic [2:0] RST_AL = 3'h0;
  localparam logic RST_RDQS = 1'b0;
  localparam logic [3:0] BEATS_BL4 = 4'h4;
  localparam logic [3:0] BEATS_BL8 = 4'h8;

  // ==========================================================
  // command and data path state types
  typedef enum logic [2:0] {cmd_nop, cmd_read, cmd_write, cmd_mode_set, cmd_other} cmd_type;
  typedef enum logic [2:0] {st_idle, st_rd_pre, st_rd_burst, st_rd_post, st_wr_burst} path_state_type;

endpackage : ddr2_burst_pkg

//--- logic/ddr2_burst_path.sv
// Purpose: burst read and write data path of a four-bank DDR2 memory
// Assumes: core_clk much faster than the link clock ck; all pins resynchronised
// Notes: one beat per ck edge; dq/dqs output enables are active low
//
// How it works
// R01 - only burst lengths four and eight accepted
// R02 - burst length from low three mode bits
// R03 - address bit three picks burst ordering
// R04 - controller never interrupts a length-four burst
// R05 - no burst stop command is decoded
// R06 - sequential order counts within nibble, then other
// R07 - interleaved order xors start with beat count
// R08 - read: cs, cas low; ras, we high
// R09 - first read beat after additive plus CAS latency
// R10 - strobe preamble low, beats on strobe edges
// R11 - read to write spacing at least BL/2+2
// R12 - reads every BL/2 clocks stream without gaps
// R13 - write decoded from cs, cas, we low
// R14 - write latency one less than read latency
// R15 - controller drives write preamble and strobed beats
// R16 - data after the last write beat ignored
// R17 - controller keeps write to read turnaround
// R18 - writes every BL/2 clocks stream without gaps
// R19 - masked beats leave location unchanged; ignored reading
// R20 - sixteen-bit organisation has two mask inputs
// R21 - eight-bit read strobe option disables masking
// R22 - controller waits analog write recovery before precharge
// R23 - early commands held for the additive latency
// R24 - length-eight read interrupted only by read
// R25 - data and strobe released when not reading

`timescale 1ns/1ps

module ddr2_burst_path (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // command pins from the controller
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ddr2_burst_pkg::BA_W-1:0] ba,
  input wire logic [ddr2_burst_pkg::ADDR_W-1:0] addr,
  // data pins
  input wire logic [ddr2_burst_pkg::DQ_W-1:0] dq_in,
  output logic [ddr2_burst_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [ddr2_burst_pkg::DM_W-1:0] dm,
  // strobe pins
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe_n,
  // organisation strap
  input wire logic org_x8
);
  import ddr2_burst_pkg::*;

  // ==========================================================
  // helper functions

  // command decode from the four strobes, sampled at a ck rise
  function automatic cmd_type decode_cmd(input logic c, input logic r, input logic a, input logic w);
    cmd_type res;
    res = cmd_other;
    if (c) begin
      res = cmd_nop;
    end else if (!r && !a && !w) begin
      res = cmd_mode_set;
    end else if (r && !a && w) begin
      res = cmd_read; // R08
    end else if (r && !a && !w) begin
      res = cmd_write; // R13
    end else if (r && a && w) begin
      res = cmd_nop;
    end
    // the burst stop encoding falls through as an ignored command
    return res; // R05
  endfunction : decode_cmd

  // column offset of a beat within its burst
  function automatic logic [2:0] col_order(input logic [2:0] start, input logic [2:0] beat,
                                           input logic is_bl8, input logic is_ilv);
    logic [2:0] res;
    res = start;
    if (is_ilv) begin
      res[1:0] = start[1:0] ^ beat[1:0]; // R07
      res[2] = is_bl8 ? (start[2] ^ beat[2]) : start[2]; // R07
    end else begin
      res[1:0] = start[1:0] + beat[1:0]; // R06
      res[2] = is_bl8 ? (start[2] ^ beat[2]) : start[2]; // R06
    end
    return res;
  endfunction : col_order

  // ==========================================================
  // pin synchronisers

  logic [SYNC_W-1:0] pin_raw, pin_meta, pin_sync;
  logic s_ck, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_dqs, s_org_x8, ck_last, dqs_last;
  logic [BA_W-1:0] s_ba;
  logic [ADDR_W-1:0] s_addr;
  logic [DM_W-1:0] s_dm;
  logic [DQ_W-1:0] s_dq;

  // every pin bundled so that all lanes see the same delay
  assign pin_raw = {ck, cs_n, ras_n, cas_n, we_n, ba, addr, dqs_in, dm, dq_in, org_x8};
  assign {s_ck, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dqs, s_dm, s_dq, s_org_x8} = pin_sync;

  // two flops per pin, then one more for edge finding
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      ck_last <= 1'b0;
      dqs_last <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      ck_last <= s_ck;
      dqs_last <= s_dqs;
    end
  end

  // edge strobes of link clock and data strobe
  logic ck_rise, ck_fall, dqs_rise, dqs_fall;
  assign ck_rise = s_ck & ~ck_last;
  assign ck_fall = ~s_ck & ck_last;
  assign dqs_rise = s_dqs & ~dqs_last;
  assign dqs_fall = ~s_dqs & dqs_last;

  // ==========================================================
  // mode registers

  cmd_type cmd;
  logic bl8, ilv, rdqs_en, mr_hit, emr_hit;
  logic [2:0] cas_lat, add_lat, bl_code, cl_code, al_code;

  assign cmd = ck_rise ? decode_cmd(s_cs_n, s_ras_n, s_cas_n, s_we_n) : cmd_nop;
  assign mr_hit = (cmd == cmd_mode_set) && (s_ba == BA_MR);
  assign emr_hit = (cmd == cmd_mode_set) && (s_ba == BA_EMR);
  assign bl_code = s_addr[MR_BL_LSB +: 3]; // R02
  assign cl_code = s_addr[MR_CL_LSB +: 3];
  assign al_code = s_addr[EMR_AL_LSB +: 3];

  // illegal codes leave the old setting in place
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bl8 <= RST_BL8;
      ilv <= RST_ILV;
      cas_lat <= RST_CL;
      add_lat <= RST_AL;
      rdqs_en <= RST_RDQS;
    end else begin
      if (mr_hit && (bl_code == BL_CODE_4 || bl_code == BL_CODE_8)) begin
        bl8 <= (bl_code == BL_CODE_8); // R01
      end
      if (mr_hit) begin
        ilv <= s_addr[MR_BT_BIT]; // R03
      end
      if (mr_hit && cl_code >= CL_MIN && cl_code <= CL_MAX) begin
        cas_lat <= cl_code;
      end
      if (emr_hit && al_code <= AL_MAX) begin
        add_lat <= al_code;
      end
      if (emr_hit) begin
        rdqs_en <= s_addr[EMR_RDQS_BIT];
      end
    end
  end

  // ==========================================================
  // posted command schedule, indexed by ck cycle

  logic [SLOT_W-1:0] ck_count, rd_lat, wr_lat, cur_slot, nxt_slot, rd_slot, wr_slot;
  logic [NUM_SLOTS-1:0] slot_valid, slot_wr;
  logic [COL_W-1:0] slot_col [NUM_SLOTS];

  assign rd_lat = {1'b0, add_lat} + {1'b0, cas_lat}; // R09
  assign wr_lat = rd_lat - 4'h1; // R14
  assign cur_slot = ck_count;
  assign nxt_slot = ck_count + 4'h1;
  assign rd_slot = ck_count + rd_lat; // R23
  assign wr_slot = ck_count + wr_lat; // R23

  // a slot is emptied as its ck cycle arrives; latency of two or more keeps set and clear apart
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ck_count <= '0;
      slot_valid <= '0;
      slot_wr <= '0;
    end else if (ck_rise) begin
      ck_count <= nxt_slot;
      slot_valid[cur_slot] <= 1'b0;
      if (cmd == cmd_read || cmd == cmd_write) begin
        slot_valid[(cmd == cmd_read) ? rd_slot : wr_slot] <= 1'b1;
        slot_wr[(cmd == cmd_read) ? rd_slot : wr_slot] <= (cmd == cmd_write);
        slot_col[(cmd == cmd_read) ? rd_slot : wr_slot] <= s_addr[COL_W-1:0];
      end
    end
  end

  // ==========================================================
  // burst engine

  path_state_type state, next_state;
  logic [COL_W-1:0] base, next_base, eff_base, beat_addr;
  logic [3:0] beat, next_beat, beats_total, eff_beat;
  logic start_rd, start_wr, pre_rd, wr_take, mask_on, next_dq_oe_n, next_dqs_out, next_dqs_oe_n;
  logic [DQ_W-1:0] mem [MEM_DEPTH];
  logic [DQ_W-1:0] next_dq_out;

  assign beats_total = bl8 ? BEATS_BL8 : BEATS_BL4; // R01
  assign start_rd = ck_rise & slot_valid[cur_slot] & ~slot_wr[cur_slot]; // R09
  assign start_wr = ck_rise & slot_valid[cur_slot] & slot_wr[cur_slot]; // R14
  assign pre_rd = ck_rise & slot_valid[nxt_slot] & ~slot_wr[nxt_slot]; // R10
  assign eff_base = (start_rd | start_wr) ? slot_col[cur_slot] : base;
  assign eff_beat = (start_rd | start_wr) ? 4'h0 : beat;
  assign beat_addr = {eff_base[COL_W-1], col_order(eff_base[2:0], eff_beat[2:0], bl8, ilv)};
  // even beats land on strobe rises, odd on falls; nothing outside a write window
  assign wr_take = (start_wr | (state == st_wr_burst)) & (eff_beat[0] ? dqs_fall : dqs_rise); // R16
  assign mask_on = ~(s_org_x8 & rdqs_en); // R21

  // next state and pin drive; a new burst start overrides any running one
  always_comb begin
    next_state = state;
    next_base = base;
    next_beat = beat;
    next_dq_out = dq_out;
    next_dq_oe_n = dq_oe_n;
    next_dqs_out = dqs_out;
    next_dqs_oe_n = dqs_oe_n;
    if (start_rd) begin
      next_state = st_rd_burst; // R12 R24
      next_base = eff_base;
      next_beat = 4'h1;
      next_dq_out = mem[beat_addr];
      next_dq_oe_n = 1'b0;
      next_dqs_out = 1'b1; // R10
      next_dqs_oe_n = 1'b0;
    end else if (start_wr) begin
      next_state = st_wr_burst; // R18
      next_base = eff_base;
      next_beat = wr_take ? 4'h1 : 4'h0;
      next_dq_oe_n = 1'b1;
      next_dqs_oe_n = 1'b1;
    end else begin
      case (state)
        st_idle: begin
          if (pre_rd) begin
            next_state = st_rd_pre;
            next_dqs_out = 1'b0; // R10
            next_dqs_oe_n = 1'b0;
          end
        end
        st_rd_pre: begin
          next_state = st_rd_pre;
        end
        st_rd_burst: begin
          if ((ck_rise || ck_fall) && beat == beats_total) begin
            next_state = pre_rd ? st_rd_pre : st_rd_post;
            next_dq_oe_n = 1'b1; // R25
            next_dqs_out = 1'b0;
          end else if (ck_rise || ck_fall) begin
            next_dq_out = mem[beat_addr];
            next_dqs_out = ~beat[0]; // R10
            next_beat = beat + 4'h1;
          end
        end
        st_rd_post: begin
          if (ck_fall) begin
            next_state = st_idle;
            next_dqs_oe_n = 1'b1; // R25
          end
        end
        st_wr_burst: begin
          if (wr_take) begin
            next_beat = beat + 4'h1;
          end
          if (wr_take && (beat + 4'h1) == beats_total) begin
            next_state = st_idle; // R16
          end
        end
        default: begin
          next_state = st_idle;
          next_dq_oe_n = 1'b1;
          next_dqs_oe_n = 1'b1;
        end
      endcase
    end
  end

  // engine registers and pin drivers, released after reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= st_idle;
      base <= '0;
      beat <= '0;
      dq_out <= '0;
      dq_oe_n <= 1'b1; // R25
      dqs_out <= 1'b0;
      dqs_oe_n <= 1'b1; // R25
    end else begin
      state <= next_state;
      base <= next_base;
      beat <= next_beat;
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
      dqs_out <= next_dqs_out;
      dqs_oe_n <= next_dqs_oe_n;
    end
  end

  // ==========================================================
  // storage array with per-byte write masking

  // mask lanes are looked at only while a write beat is taken
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DM_W; i++) begin
      if (wr_take && !(s_dm[i] && mask_on)) begin
        mem[beat_addr][8*i +: 8] <= s_dq[8*i +: 8]; // R19 R20
      end
    end
  end

endmodule : ddr2_burst_path

//--- testbench/ddr2_burst_path_asserts.sv
// Purpose: read-side port checks for the burst data path
// Assumes: link clock half period is four core cycles
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module ddr2_burst_path_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // read outputs
  input wire logic [ddr2_burst_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic dqs_out,
  input wire logic dqs_oe_n
);
  import ddr2_burst_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic dqs_q;
  logic [5:0] beats;
  // ==========================================================
  // strobe edges counted over one read stream
  always_ff @(posedge core_clk) begin
    dqs_q <= dqs_out;
    beats <= (!reset_n || dq_oe_n) ? 6'h00 : beats + {5'h00, dqs_out != dqs_q};
  end
  // ==========================================================
  // properties
  AST_OE_PAIR: assert property (!dq_oe_n |-> !dqs_oe_n)
    else $error("data driven without strobe");
  AST_RESET_IDLE: assert property ($rose(reset_n) |-> dq_oe_n && dqs_oe_n)
    else $error("pins driven after reset");
  AST_PREAMBLE: assert property ($fell(dqs_oe_n) |-> (dq_oe_n && !dqs_out) [*6] ##[1:3] !dq_oe_n)
    else $error("strobe preamble wrong");
  AST_FIRST_BEAT: assert property ($fell(dq_oe_n) |-> $rose(dqs_out))
    else $error("first beat not on strobe rise");
  AST_BEAT_TIME: assert property (!dq_oe_n && $changed(dqs_out) |=>
    $stable(dqs_out) [*3] ##1 ($changed(dqs_out) || dq_oe_n))
    else $error("beat spacing wrong");
  AST_DATA_HOLD: assert property (!dq_oe_n && !$past(dq_oe_n) && $stable(dqs_out) |-> $stable(dq_out))
    else $error("data moved inside a beat");
  AST_POSTAMBLE: assert property ($rose(dq_oe_n) |-> (!dqs_out && !dqs_oe_n) [*3] ##[1:2] dqs_oe_n)
    else $error("postamble wrong");
  AST_WHOLE_BURST: assert property ($rose(dq_oe_n) |-> beats != 6'h00 && beats[1:0] == 2'h0)
    else $error("partial burst");
  COV_READ: cover property ($fell(dq_oe_n));
  COV_STREAM: cover property ($rose(dq_oe_n) && beats == 6'h10);
  COV_BL8: cover property ($rose(dq_oe_n) && beats == 6'h08);
endmodule : ddr2_burst_path_asserts

bind ddr2_burst_path ddr2_burst_path_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n), .dq_out(dq_out),
  .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));

//--- testbench/ddr2_ctrl_model.sv
// Purpose: memory controller model driving link clock, commands and write data
// Assumes: link clock runs free; one command per link cycle
// Notes: strobe idles high; data after a burst is inverted junk
`timescale 1ns/1ps
module ddr2_ctrl_model (
  // link clock and command pins
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ddr2_burst_pkg::BA_W-1:0] ba,
  output logic [ddr2_burst_pkg::ADDR_W-1:0] addr,
  // write data and strobe
  output logic [ddr2_burst_pkg::DQ_W-1:0] dq_in,
  output logic [ddr2_burst_pkg::DM_W-1:0] dm,
  output logic dqs_in
);
  import ddr2_burst_pkg::*;
  int bl = 4;
  int cl = 3;
  int al = 0;
  int rl = 3;
  int nck = 0;
  int first_ck = 0;
  logic ilv = 1'b0;
  logic rdqs = 1'b0;
  // ==========================================================
  // link clock, kept off the core clock edges
  initial begin
    {ck, cs_n, ras_n, cas_n, we_n} = 5'h0F;
    ba = 2'h0;
    addr = 13'h0000;
    dq_in = 16'h0000;
    dm = 2'h0;
    dqs_in = 1'b1;
    #7;
    forever #100 ck = ~ck;
  end
  always @(posedge ck) nck++;
  // one command across a link rise, then deselect
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    addr = ~a;
  endtask : issue
  // mode set; an illegal code leaves its field alone
  task automatic mrs(input logic [1:0] b, input logic [12:0] a);
    issue(4'h0, b, a);
    if (b == 2'h0) begin
      if (a[2:0] == BL_CODE_4 || a[2:0] == BL_CODE_8) bl = a[0] ? 8 : 4;
      if (a[6:4] >= CL_MIN) cl = a[6:4];
      ilv = a[3];
    end else begin
      if (a[5:3] <= AL_MAX) al = a[5:3];
      rdqs = a[11];
    end
    rl = al + cl;
  endtask : mrs
  // reads every BL/2 clocks, never interrupted or stopped
  task automatic rd(input logic [3:0] s, input int nb);
    for (int i = 0; i < nb; i++) begin
      if (i > 0) repeat (bl / 2 - 2) @(negedge ck);
      issue(4'h5, 2'h0, {9'h000, s + 4'(i * bl)});
      if (i == 0) first_ck = nck;
    end
  endtask : rd
  // writes every BL/2 clocks; preamble, one beat per strobe edge, then a junk edge
  task automatic wr(input logic [3:0] s, input int nb, input logic [15:0] base, input bit msk);
    fork
      for (int i = 0; i < nb; i++) begin
        if (i > 0) repeat (bl / 2 - 2) @(negedge ck);
        issue(4'h4, 2'h0, {9'h000, s + 4'(i * bl)});
      end
      begin
        @(negedge ck);
        repeat (rl - 1) @(posedge ck);
        dqs_in = 1'b0;
        // preamble lasts a whole link clock so beat 0 rises with the write-latency edge
        #100;
        for (int k = 0; k < nb * bl; k++) begin
          #50 dq_in = base + 16'(k);
          dm = (msk && k % bl == 1) ? 2'h1 : ((msk && k % bl == 2) ? 2'h2 : 2'h0);
          #50 dqs_in = ~dqs_in;
        end
        #50 dq_in = ~dq_in;
        dm = 2'h0;
        #50 dqs_in = ~dqs_in;
      end
    join
  endtask : wr
endmodule : ddr2_ctrl_model

//--- testbench/ddr2_burst_path_bench.sv
// Purpose: self-checking bench for the burst data path
// Assumes: controller model drives the link; bench keeps the expected array
// Notes: a read beat is taken on each strobe edge while data is driven
`timescale 1ns/1ps
module ddr2_burst_path_bench;
  import ddr2_burst_pkg::*;
  logic core_clk, reset_n, org_x8, ck, cs_n, ras_n, cas_n, we_n;
  logic dq_oe_n, dqs_in, dqs_out, dqs_oe_n, pdqs;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [DM_W-1:0] dm;
  logic [DQ_W-1:0] mem [MEM_DEPTH];
  logic [DQ_W-1:0] got [$];
  int gck [$];
  int fails, n_compared;
  // ==========================================================
  // design and controller
  ddr2_burst_path dut (.core_clk(core_clk), .reset_n(reset_n), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dm(dm), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .org_x8(org_x8));
  ddr2_ctrl_model ctrl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dq_in(dq_in), .dm(dm), .dqs_in(dqs_in));
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // take read beats where outputs are settled
  always @(negedge core_clk) begin
    if (!dq_oe_n && dqs_out !== pdqs) begin
      got.push_back(dq_out);
      gck.push_back(ctrl.nck);
    end
    pdqs = dqs_out;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [3:0] col(input logic [3:0] s, input int k);
    logic [2:0] o;
    o = ctrl.ilv ? s[2:0] ^ 3'(k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
    return (ctrl.bl == 8) ? {s[3], o} : {s[3:2], o[1:0]};
  endfunction : col
  task automatic wr(input logic [3:0] s, input int nb, input logic [15:0] base, input bit msk);
    logic [3:0] c;
    logic [15:0] v;
    ctrl.wr(s, nb, base, msk);
    for (int i = 0; i < nb * ctrl.bl; i++) begin
      c = col(s + 4'(i / ctrl.bl * ctrl.bl), i % ctrl.bl);
      v = base + 16'(i);
      if (msk && i % ctrl.bl == 1 && !(org_x8 && ctrl.rdqs)) v[7:0] = mem[c][7:0];
      if (msk && i % ctrl.bl == 2 && !(org_x8 && ctrl.rdqs)) v[15:8] = mem[c][15:8];
      mem[c] = v;
    end
    repeat (6) @(posedge ck);
  endtask : wr
  task automatic rd(input logic [3:0] s, input int nb);
    got.delete();
    gck.delete();
    ctrl.rd(s, nb);
    // a burst stop encoding while data is due must not cut the stream
    ctrl.issue(4'h6, 2'h0, 13'h0000);
    repeat (ctrl.rl + ctrl.bl / 2 + 2) @(posedge ck);
    check(16'(got.size()), 16'(nb * ctrl.bl));
    check(16'(gck[0]), 16'(ctrl.first_ck + ctrl.rl));
    for (int i = 0; i < nb * ctrl.bl; i++) check(got[i], mem[col(s + 4'(i / ctrl.bl * ctrl.bl), i % ctrl.bl)]);
  endtask : rd
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ==========================================================
  // watchdog
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  // test sequence
  initial begin
    reset_n = 1'b0;
    org_x8 = 1'b0;
    repeat (2) @(posedge core_clk);
    #2 reset_n = 1'b1;
    wr(4'h1, 4, 16'h1000, 1'b0);
    rd(4'h1, 4);
    wr(4'h6, 1, 16'h2000, 1'b1);
    rd(4'h4, 1);
    ctrl.mrs(2'h0, 13'h004B);
    ctrl.mrs(2'h1, 13'h0010);
    wr(4'h3, 2, 16'h3000, 1'b1);
    rd(4'h5, 2);
    ctrl.mrs(2'h0, 13'h0017);
    ctrl.mrs(2'h1, 13'h0000);
    rd(4'h6, 2);
    @(posedge core_clk);
    #2 org_x8 = 1'b1;
    ctrl.mrs(2'h1, 13'h0800);
    wr(4'h2, 1, 16'h4000, 1'b1);
    rd(4'h2, 1);
    stop_test();
  end
endmodule : ddr2_burst_path_bench
